// [qcc_queue_command.sv]
// Transmit and receive queue command registers with Avalon-MM slave
//
// Contract
// R1 - Writing one to manual enqueue queues the single current prepared frame.
// R2 - Manual enqueue self-clears when the frame is transmitted; host waits for it.
// R3 - Auto-enqueue set queues every prepared transmit frame automatically.
// R4 - Host keeps manual enqueue zero while setting auto-enqueue.
// R5 - Space monitor set raises status bit 6 once requested space is free.
// R6 - Space monitor self-clears after frame transmits; host waits before rearming.
// R7 - Bit 12 shows the receive interrupt came from the duration threshold.
// R8 - Bit 11 shows the receive interrupt came from the byte-count threshold.
// R9 - Bit 10 shows the receive interrupt came from the frame-count threshold.
// R10 - Threshold status bits refresh only when host writes one to status bit 13.
// R11 - Alignment enable inserts two bytes before each received frame header.
// R12 - Duration enable raises status bit 13 once frame age exceeds threshold.
// R13 - Byte-count enable raises status bit 13 once queued bytes exceed threshold.
module qcc_queue_command (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [qcc_pkg::ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire qcc_pkg::qcc_tx_level_t i_tx_level,
  input wire qcc_pkg::qcc_rx_level_t i_rx_level,
  output logic o_tx_enqueue,
  output logic o_tx_auto_enqueue,
  output logic o_rx_align_offset,
  output logic o_irq
);
  logic [1:0] rst_sync_reg;
  wire rst_n = rst_sync_reg[1];

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
    merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  function automatic logic [15:0] lanes16(input logic [31:0] wd, input logic [3:0] be);
    lanes16 = {be[1] ? wd[15:8] : 8'h00, be[0] ? wd[7:0] : 8'h00};
  endfunction

  // Bus handshake: one wait cycle, then the access completes
  logic wait_reg;
  logic [31:0] rdata_reg;
  wire req = i_avs_read || i_avs_write;
  wire commit = req && !wait_reg;
  wire wr_commit = commit && i_avs_write;
  wire [qcc_pkg::IDX_W-1:0] idx = i_avs_address[qcc_pkg::ADDR_W-1:2];
  wire [15:0] wlanes = lanes16(i_avs_writedata, i_avs_byteenable);

  wire sel_txq = (idx == qcc_pkg::IDX_TXQ_CMD);
  wire sel_rxq = (idx == qcc_pkg::IDX_RXQ_CMD);
  wire sel_dur = (idx == qcc_pkg::IDX_RX_DUR_THR);
  wire sel_byte = (idx == qcc_pkg::IDX_RX_BYTE_THR);
  wire sel_frame = (idx == qcc_pkg::IDX_RX_FRAME_THR);
  wire sel_space = (idx == qcc_pkg::IDX_TX_SPACE_REQ);
  wire sel_mask = (idx == qcc_pkg::IDX_IRQ_MASK);
  wire sel_stat = (idx == qcc_pkg::IDX_IRQ_STATUS);

  logic [15:0] txq_reg;
  logic [15:0] rxq_ctl_reg;
  logic [2:0] hit_reg;
  logic [15:0] dur_thr_reg;
  logic [15:0] byte_thr_reg;
  logic [15:0] frame_thr_reg;
  logic [15:0] space_req_reg;
  logic [15:0] irq_mask_reg;
  logic [15:0] irq_stat_reg;
  logic enq_reg;
  logic irq_reg;
  logic [15:0] age;

  qcc_age_timer #(
    .TICK_CYCLES(qcc_pkg::DUR_TICK_CYCLES),
    .AGE_W(16)
  ) u_age (
    .i_clk(i_clk),
    .i_rst_n(rst_n),
    .i_active(i_rx_level.queue_busy),
    .o_age(age)
  );

  // Threshold comparisons
  wire dur_hit = rxq_ctl_reg[qcc_pkg::RXQ_DUR_EN_BIT] && (age > dur_thr_reg); // R12
  wire byte_hit = rxq_ctl_reg[qcc_pkg::RXQ_BYTE_EN_BIT]
                  && (i_rx_level.byte_count > byte_thr_reg); // R13
  wire frame_hit = rxq_ctl_reg[qcc_pkg::RXQ_FRAME_EN_BIT]
                   && (i_rx_level.frame_count > frame_thr_reg);
  wire rx_thr_event = dur_hit || byte_hit || frame_hit;

  // Transmit space monitor
  wire space_event = txq_reg[qcc_pkg::TXQ_MONITOR_BIT]
                     && (i_tx_level.free_space >= space_req_reg); // R5

  // Transmit command write decode
  wire txq_wr = wr_commit && sel_txq;
  wire manual_wr = txq_wr && wlanes[qcc_pkg::TXQ_MANUAL_BIT]; // R1
  wire monitor_wr = txq_wr && wlanes[qcc_pkg::TXQ_MONITOR_BIT];
  wire auto_wr_val = i_avs_byteenable[0] ? i_avs_writedata[qcc_pkg::TXQ_AUTO_BIT]
                                         : txq_reg[qcc_pkg::TXQ_AUTO_BIT];
  wire auto_next = txq_wr ? auto_wr_val : txq_reg[qcc_pkg::TXQ_AUTO_BIT];
  // Write wins over completion so an enqueue in the done cycle is not lost
  wire manual_next = manual_wr
                     || (txq_reg[qcc_pkg::TXQ_MANUAL_BIT] && !i_tx_level.frame_done); // R2
  wire monitor_next = monitor_wr
                      || (txq_reg[qcc_pkg::TXQ_MONITOR_BIT] && !i_tx_level.frame_done); // R6
  // Auto mode issues one enqueue per prepared frame, spaced by a cycle
  wire auto_enq = txq_reg[qcc_pkg::TXQ_AUTO_BIT] && i_tx_level.frame_ready && !enq_reg; // R3

  logic [15:0] txq_next;
  always_comb begin
    txq_next = 16'h0000;
    txq_next[qcc_pkg::TXQ_MANUAL_BIT] = manual_next;
    txq_next[qcc_pkg::TXQ_MONITOR_BIT] = monitor_next;
    txq_next[qcc_pkg::TXQ_AUTO_BIT] = auto_next;
  end

  // Interrupt status: set wins over write-one-to-clear
  wire stat_wr = wr_commit && sel_stat;
  wire [15:0] stat_clr = stat_wr ? wlanes : 16'h0000;
  wire [15:0] stat_set = ({15'h0000, rx_thr_event} << qcc_pkg::IRQ_RX_THR_BIT)
                         | ({15'h0000, space_event} << qcc_pkg::IRQ_TX_SPACE_BIT);
  wire [15:0] irq_stat_next = ((irq_stat_reg & ~stat_clr) | stat_set) & qcc_pkg::IRQ_USED_MASK;
  wire hit_refresh = stat_wr && wlanes[qcc_pkg::IRQ_RX_THR_BIT]; // R10
  wire irq_next = |(irq_stat_next & irq_mask_reg);

  // Read mux
  logic [15:0] rxq_view;
  always_comb begin
    rxq_view = rxq_ctl_reg & qcc_pkg::RXQ_RW_MASK;
    rxq_view[qcc_pkg::RXQ_DUR_HIT_BIT] = hit_reg[2]; // R7
    rxq_view[qcc_pkg::RXQ_BYTE_HIT_BIT] = hit_reg[1]; // R8
    rxq_view[qcc_pkg::RXQ_FRAME_HIT_BIT] = hit_reg[0]; // R9
  end

  wire [15:0] rd_mux = sel_txq ? txq_reg :
                       sel_rxq ? rxq_view :
                       sel_dur ? dur_thr_reg :
                       sel_byte ? byte_thr_reg :
                       sel_frame ? frame_thr_reg :
                       sel_space ? space_req_reg :
                       sel_mask ? irq_mask_reg :
                       sel_stat ? irq_stat_reg : 16'h0000;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_reg <= 1'b1;
      rdata_reg <= 32'h0000_0000;
    end else begin
      wait_reg <= !(req && wait_reg);
      if (req && wait_reg) begin
        rdata_reg <= {16'h0000, rd_mux};
      end
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      txq_reg <= qcc_pkg::CMD_RST;
      enq_reg <= 1'b0;
    end else begin
      txq_reg <= txq_next & qcc_pkg::TXQ_RW_MASK;
      enq_reg <= manual_wr || auto_enq; // R1 R3
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxq_ctl_reg <= qcc_pkg::CMD_RST;
      dur_thr_reg <= qcc_pkg::THR_RST;
      byte_thr_reg <= qcc_pkg::THR_RST;
      frame_thr_reg <= qcc_pkg::THR_RST;
      space_req_reg <= qcc_pkg::THR_RST;
      irq_mask_reg <= qcc_pkg::IRQ_RST;
    end else if (wr_commit) begin
      if (sel_rxq) begin
        rxq_ctl_reg <= merge16(rxq_ctl_reg, i_avs_writedata, i_avs_byteenable)
                       & qcc_pkg::RXQ_RW_MASK;
      end
      if (sel_dur) begin
        dur_thr_reg <= merge16(dur_thr_reg, i_avs_writedata, i_avs_byteenable);
      end
      if (sel_byte) begin
        byte_thr_reg <= merge16(byte_thr_reg, i_avs_writedata, i_avs_byteenable);
      end
      if (sel_frame) begin
        frame_thr_reg <= merge16(frame_thr_reg, i_avs_writedata, i_avs_byteenable);
      end
      if (sel_space) begin
        space_req_reg <= merge16(space_req_reg, i_avs_writedata, i_avs_byteenable);
      end
      if (sel_mask) begin
        irq_mask_reg <= merge16(irq_mask_reg, i_avs_writedata, i_avs_byteenable)
                        & qcc_pkg::IRQ_USED_MASK;
      end
    end
  end

  // Cause bits are a snapshot; they do not track the live comparators
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_reg <= qcc_pkg::IRQ_RST;
      hit_reg <= 3'b000;
      irq_reg <= 1'b0;
    end else begin
      irq_stat_reg <= irq_stat_next; // R5 R12 R13
      irq_reg <= irq_next;
      if (hit_refresh) begin
        hit_reg <= {dur_hit, byte_hit, frame_hit}; // R10
      end
    end
  end

  assign o_avs_readdata = rdata_reg;
  assign o_avs_waitrequest = wait_reg;
  assign o_tx_enqueue = enq_reg;
  assign o_tx_auto_enqueue = txq_reg[qcc_pkg::TXQ_AUTO_BIT]; // R3
  assign o_rx_align_offset = rxq_ctl_reg[qcc_pkg::RXQ_ALIGN_BIT]; // R11
  assign o_irq = irq_reg;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!rst_n);

  // Transmit command bits
  a_manual_enqueue_pulse: assert property ( // R1
    manual_wr
    |=> o_tx_enqueue && txq_reg[qcc_pkg::TXQ_MANUAL_BIT])
    else $error("manual enqueue not issued");

  a_enqueue_one_cycle: assert property ( // R1
    o_tx_enqueue && !o_tx_auto_enqueue
    |=> !o_tx_enqueue)
    else $error("manual enqueue longer than one cycle");

  a_manual_self_clear: assert property ( // R2
    txq_reg[qcc_pkg::TXQ_MANUAL_BIT] && i_tx_level.frame_done && !manual_wr
    |=> !txq_reg[qcc_pkg::TXQ_MANUAL_BIT])
    else $error("manual enqueue not cleared");

  a_manual_holds: assert property ( // R2
    txq_reg[qcc_pkg::TXQ_MANUAL_BIT] && !i_tx_level.frame_done
    |=> txq_reg[qcc_pkg::TXQ_MANUAL_BIT])
    else $error("manual enqueue dropped early");

  a_auto_enqueue: assert property ( // R3
    o_tx_auto_enqueue && i_tx_level.frame_ready && !o_tx_enqueue
    |=> o_tx_enqueue)
    else $error("auto enqueue missed");

  a_space_irq_set: assert property ( // R5
    space_event
    |=> irq_stat_reg[qcc_pkg::IRQ_TX_SPACE_BIT])
    else $error("space interrupt not raised");

  a_monitor_clear: assert property ( // R6
    txq_reg[qcc_pkg::TXQ_MONITOR_BIT] && i_tx_level.frame_done && !monitor_wr
    |=> !txq_reg[qcc_pkg::TXQ_MONITOR_BIT])
    else $error("space monitor not cleared");

  a_monitor_holds: assert property ( // R6
    txq_reg[qcc_pkg::TXQ_MONITOR_BIT] && !i_tx_level.frame_done
    |=> txq_reg[qcc_pkg::TXQ_MONITOR_BIT])
    else $error("space monitor dropped early");

  // Receive thresholds and causes
  a_hit_snapshot: assert property ( // R7 R8 R9
    hit_refresh
    |=> rxq_view[qcc_pkg::RXQ_DUR_HIT_BIT] == $past(dur_hit)
    && rxq_view[qcc_pkg::RXQ_BYTE_HIT_BIT] == $past(byte_hit)
    && rxq_view[qcc_pkg::RXQ_FRAME_HIT_BIT] == $past(frame_hit))
    else $error("threshold cause not captured");

  a_hit_frozen: assert property ( // R10
    !hit_refresh
    |=> $stable(hit_reg))
    else $error("threshold cause changed without refresh");

  a_align_follows: assert property ( // R11
    wr_commit && sel_rxq && i_avs_byteenable[1]
    |=> o_rx_align_offset == $past(i_avs_writedata[qcc_pkg::RXQ_ALIGN_BIT]))
    else $error("align offset mismatch");

  a_rx_irq_set: assert property ( // R12 R13
    dur_hit || byte_hit || frame_hit
    |=> irq_stat_reg[qcc_pkg::IRQ_RX_THR_BIT])
    else $error("rx irq missing");

  // Bus and interrupt output
  a_bus_answer: assert property (
    req && wait_reg
    |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
    else $error("bus answer timing wrong");

  a_stat_w1c: assert property (
    stat_wr && wlanes[qcc_pkg::IRQ_TX_SPACE_BIT] && !space_event
    |=> !irq_stat_reg[qcc_pkg::IRQ_TX_SPACE_BIT])
    else $error("space status not cleared");

  a_irq_level: assert property (
    o_irq == |(irq_stat_reg & $past(irq_mask_reg)))
    else $error("interrupt output wrong");
endmodule

// [qcc_pkg.sv]
// Shared constants and carrier types for the queue command block
package qcc_pkg;
  localparam int ADDR_W = 12;
  localparam int IDX_W = 10;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_TXQ_CMD = 10'h080;
  localparam logic [IDX_W-1:0] IDX_RXQ_CMD = 10'h082;
  localparam logic [IDX_W-1:0] IDX_RX_DUR_THR = 10'h08c;
  localparam logic [IDX_W-1:0] IDX_RX_BYTE_THR = 10'h08e;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 10'h090;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 10'h092;
  localparam logic [IDX_W-1:0] IDX_RX_FRAME_THR = 10'h09c;
  localparam logic [IDX_W-1:0] IDX_TX_SPACE_REQ = 10'h09e;

  // Transmit command fields
  localparam int TXQ_MANUAL_BIT = 0;
  localparam int TXQ_MONITOR_BIT = 1;
  localparam int TXQ_AUTO_BIT = 2;
  localparam logic [15:0] TXQ_RW_MASK = 16'h0007;

  // Receive command fields
  localparam int RXQ_FRAME_EN_BIT = 5;
  localparam int RXQ_BYTE_EN_BIT = 6;
  localparam int RXQ_DUR_EN_BIT = 7;
  localparam int RXQ_ALIGN_BIT = 9;
  localparam int RXQ_FRAME_HIT_BIT = 10;
  localparam int RXQ_BYTE_HIT_BIT = 11;
  localparam int RXQ_DUR_HIT_BIT = 12;
  localparam logic [15:0] RXQ_RW_MASK = 16'h02e0;

  // Interrupt status fields
  localparam int IRQ_TX_SPACE_BIT = 6;
  localparam int IRQ_RX_THR_BIT = 13;
  localparam logic [15:0] IRQ_USED_MASK = 16'h2040;

  // Reset values
  localparam logic [15:0] CMD_RST = 16'h0000;
  localparam logic [15:0] THR_RST = 16'h0000;
  localparam logic [15:0] IRQ_RST = 16'h0000;

  // Duration threshold counts in microsecond ticks
  localparam int CLK_PERIOD_NS = 10;
  localparam int DUR_TICK_NS = 1000;
  localparam int DUR_TICK_CYCLES = (DUR_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef struct packed {
    logic [15:0] byte_count;
    logic [15:0] frame_count;
    logic queue_busy;
  } qcc_rx_level_t;

  typedef struct packed {
    logic [15:0] free_space;
    logic frame_ready;
    logic frame_done;
  } qcc_tx_level_t;
endpackage

// [qcc_age_timer.sv]
// Age of the oldest queued receive frame, in duration ticks
module qcc_age_timer #(
  parameter int TICK_CYCLES = qcc_pkg::DUR_TICK_CYCLES,
  parameter int AGE_W = 16
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_active,
  output logic [AGE_W-1:0] o_age
);
  localparam int PRE_W = $clog2(TICK_CYCLES + 1);

  // Refused while elaborating, before any clock runs
  if (TICK_CYCLES < 1 || AGE_W < 1) begin
    $error("qcc_age_timer: bad parameters");
  end

  logic [PRE_W-1:0] pre_reg;
  logic [AGE_W-1:0] age_reg;
  wire tick = (pre_reg == PRE_W'(TICK_CYCLES - 1));
  wire age_full = &age_reg;

  // Saturates so a stale queue never wraps back under the threshold
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pre_reg <= '0;
      age_reg <= '0;
    end else if (!i_active) begin
      pre_reg <= '0;
      age_reg <= '0;
    end else begin
      pre_reg <= tick ? '0 : pre_reg + 1'b1;
      if (tick && !age_full) begin
        age_reg <= age_reg + 1'b1;
      end
    end
  end

  assign o_age = age_reg;
endmodule

// [qcc_tx_engine_model.sv]
// Transmit engine model: prepared frames and transmit completion
module qcc_tx_engine_model (
  input wire logic i_clk,
  input wire logic i_prepare,
  input wire logic [7:0] i_latency,
  input wire logic i_enqueue,
  output logic o_frame_ready,
  output logic o_frame_done
);
  timeunit 1ns;
  timeprecision 1ps;
  int prepared = 0;
  int countdown = 0;
  assign o_frame_ready = (prepared > 0);
  initial o_frame_done = 1'b0;
  // Each enqueue pulse consumes exactly one prepared frame
  always @(posedge i_clk) begin
    prepared <= prepared + (i_prepare ? 1 : 0) - (i_enqueue ? 1 : 0);
    o_frame_done <= (countdown == 1);
    if (i_enqueue) begin
      countdown <= i_latency;
    end else if (countdown > 0) begin
      countdown <= countdown - 1;
    end
  end
endmodule

// [qcc_queue_command_tb_top.sv]
// Self-checking bench for the queue command registers
module qcc_queue_command_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic [11:0] avs_address = 12'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [3:0] lanes = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [15:0] free_space = 16'h0;
  qcc_pkg::qcc_rx_level_t rx_level = '0;
  qcc_pkg::qcc_tx_level_t tx_level;
  logic prepare = 1'b0;
  logic frame_ready;
  logic frame_done;
  logic tx_enqueue;
  logic tx_auto;
  logic rx_align;
  logic irq;
  int err_count = 0;
  int n_tests = 0;
  int cycles = 0;
  int enq_seen = 0;
  logic [9:0] regs [10] = '{qcc_pkg::IDX_TXQ_CMD, qcc_pkg::IDX_RXQ_CMD, qcc_pkg::IDX_RX_DUR_THR,
    qcc_pkg::IDX_RX_BYTE_THR, qcc_pkg::IDX_IRQ_MASK, qcc_pkg::IDX_IRQ_STATUS,
    qcc_pkg::IDX_RX_FRAME_THR, qcc_pkg::IDX_TX_SPACE_REQ, 10'h0a0, 10'h3ff};
  assign tx_level = {free_space, frame_ready, frame_done};
  always #5 i_clk = ~i_clk;
  qcc_queue_command u_qcc_queue_command (.i_clk(i_clk), .i_arst_n(i_arst_n),
    .i_avs_address(avs_address), .i_avs_read(avs_read), .i_avs_write(avs_write),
    .i_avs_writedata(avs_writedata), .i_avs_byteenable(avs_byteenable),
    .o_avs_readdata(avs_readdata),
    .o_avs_waitrequest(avs_waitrequest), .i_tx_level(tx_level), .i_rx_level(rx_level),
    .o_tx_enqueue(tx_enqueue), .o_tx_auto_enqueue(tx_auto), .o_rx_align_offset(rx_align),
    .o_irq(irq));
  qcc_tx_engine_model u_qcc_tx_engine_model (.i_clk(i_clk), .i_prepare(prepare),
    .i_latency(8'h28), .i_enqueue(tx_enqueue), .o_frame_ready(frame_ready),
    .o_frame_done(frame_done));
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Ceiling well above the roughly 800 cycles the sequence needs
  always @(posedge i_clk) begin
    cycles++;
    if (tx_enqueue === 1'b1) begin
      enq_seen++;
    end
    if (cycles == 40000) begin
      err_count++;
      complete_run();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] want, input string what);
    n_tests++;
    if (got !== want) begin
      err_count++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, want);
    end
  endtask
  task automatic bus(input logic wr, input logic [9:0] idx, input logic [15:0] wd,
    output logic [31:0] rd);
    @(posedge i_clk);
    avs_address <= {idx, 2'b00};
    avs_writedata <= {16'($urandom), wd};
    avs_byteenable <= lanes;
    avs_write <= wr;
    avs_read <= ~wr;
    // Only the cycle ceiling ends a wait that never answers
    do begin
      @(posedge i_clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wr_reg(input logic [9:0] idx, input logic [15:0] wd);
    logic [31:0] dummy;
    bus(1'b1, idx, wd, dummy);
  endtask
  task automatic rd_chk(input logic [9:0] idx, input logic [15:0] want, input string what);
    logic [31:0] rd;
    bus(1'b0, idx, 16'h0000, rd);
    check(rd, {16'h0000, want}, what);
  endtask
  task automatic prep_frames(input int n);
    @(posedge i_clk);
    prepare <= 1'b1;
    repeat (n) @(posedge i_clk);
    prepare <= 1'b0;
  endtask
  initial begin
    logic [15:0] thr;
    logic [31:0] rd;
    int n;
    void'($urandom(48581));
    repeat (20) @(posedge i_clk);
    i_arst_n <= 1'b1;
    repeat (3) @(posedge i_clk);
    foreach (regs[i]) rd_chk(regs[i], 16'h0000, "reset value");
    wr_reg(10'h0a0, 16'hffff);
    rd_chk(10'h0a0, 16'h0000, "unmapped");
    wr_reg(qcc_pkg::IDX_RXQ_CMD, 16'hffff);
    rd_chk(qcc_pkg::IDX_RXQ_CMD, qcc_pkg::RXQ_RW_MASK, "rx command rw");
    check(rx_align, 1'b1, "align on");
    wr_reg(qcc_pkg::IDX_RXQ_CMD, 16'h0000);
    // The write lands at the edge the task returns on
    @(posedge i_clk);
    check(rx_align, 1'b0, "align off");
    wr_reg(qcc_pkg::IDX_RX_DUR_THR, 16'h1234);
    lanes = 4'h1;
    wr_reg(qcc_pkg::IDX_RX_DUR_THR, 16'habcd);
    lanes = 4'h2;
    wr_reg(qcc_pkg::IDX_RX_BYTE_THR, 16'habcd);
    lanes = 4'hf;
    rd_chk(qcc_pkg::IDX_RX_DUR_THR, 16'h12cd, "low lane only");
    rd_chk(qcc_pkg::IDX_RX_BYTE_THR, 16'hab00, "high lane only");
    wr_reg(qcc_pkg::IDX_RX_DUR_THR, 16'h0000);
    wr_reg(qcc_pkg::IDX_RX_BYTE_THR, 16'h0000);
    $display("test registers done");
    prep_frames(1);
    enq_seen = 0;
    wr_reg(qcc_pkg::IDX_TXQ_CMD, 16'h0001);
    rd_chk(qcc_pkg::IDX_TXQ_CMD, 16'h0001, "manual held");
    repeat (60) @(posedge i_clk);
    check(enq_seen, 1, "manual pulses");
    rd_chk(qcc_pkg::IDX_TXQ_CMD, 16'h0000, "manual cleared");
    $display("test manual done");
    prep_frames(3);
    enq_seen = 0;
    wr_reg(qcc_pkg::IDX_TXQ_CMD, 16'h0004);
    repeat (20) @(posedge i_clk);
    check(enq_seen, 3, "auto pulses");
    check(tx_auto, 1'b1, "auto level");
    wr_reg(qcc_pkg::IDX_TXQ_CMD, 16'h0000);
    repeat (60) @(posedge i_clk);
    $display("test auto done");
    thr = 16'($urandom_range(16'hfff0, 16'h0100));
    wr_reg(qcc_pkg::IDX_TX_SPACE_REQ, thr);
    free_space <= thr - 16'h0001;
    wr_reg(qcc_pkg::IDX_IRQ_MASK, 16'h0040);
    wr_reg(qcc_pkg::IDX_TXQ_CMD, 16'h0002);
    repeat (4) @(posedge i_clk);
    rd_chk(qcc_pkg::IDX_IRQ_STATUS, 16'h0000, "space short");
    free_space <= thr;
    repeat (3) @(posedge i_clk);
    rd_chk(qcc_pkg::IDX_IRQ_STATUS, 16'h0040, "space met");
    check(irq, 1'b1, "space irq");
    prep_frames(1);
    wr_reg(qcc_pkg::IDX_TXQ_CMD, 16'h0001);
    repeat (60) @(posedge i_clk);
    rd_chk(qcc_pkg::IDX_TXQ_CMD, 16'h0000, "monitor cleared");
    free_space <= 16'h0000;
    wr_reg(qcc_pkg::IDX_IRQ_STATUS, 16'h0040);
    rd_chk(qcc_pkg::IDX_IRQ_STATUS, 16'h0000, "space cleared");
    check(irq, 1'b0, "irq low");
    $display("test space done");
    wr_reg(qcc_pkg::IDX_IRQ_MASK, 16'h2000);
    for (int k = 0; k < 3; k++) begin
      thr = (k == 2) ? 16'h0002 : 16'($urandom_range(200, 2));
      wr_reg((k == 0) ? qcc_pkg::IDX_RX_FRAME_THR : (k == 1) ? qcc_pkg::IDX_RX_BYTE_THR
        : qcc_pkg::IDX_RX_DUR_THR, thr);
      wr_reg(qcc_pkg::IDX_RXQ_CMD, 16'h0020 << k);
      if (k < 2) begin
        // Equal to the threshold must not count as exceeding it
        if (k == 0) rx_level.frame_count <= thr;
        else rx_level.byte_count <= thr;
        repeat (4) @(posedge i_clk);
        rd_chk(qcc_pkg::IDX_IRQ_STATUS, 16'h0000, "at threshold");
      end
      if (k == 0) rx_level.frame_count <= thr + 16'h0001;
      else if (k == 1) rx_level.byte_count <= thr + 16'h0001;
      else rx_level.queue_busy <= 1'b1;
      n = 0;
      do begin
        bus(1'b0, qcc_pkg::IDX_IRQ_STATUS, 16'h0000, rd);
        n++;
      end while (rd[13] !== 1'b1 && n < 300);
      check(rd, 32'h2000, "threshold hit");
      check(irq, 1'b1, "rx irq");
      rd_chk(qcc_pkg::IDX_RXQ_CMD, 16'h0020 << k, "cause not yet");
      wr_reg(qcc_pkg::IDX_IRQ_STATUS, 16'h2000);
      rd_chk(qcc_pkg::IDX_RXQ_CMD, (16'h0020 << k) | (16'h0400 << k), "cause");
      rx_level <= '0;
      repeat (3) @(posedge i_clk);
      wr_reg(qcc_pkg::IDX_IRQ_STATUS, 16'h2000);
      rd_chk(qcc_pkg::IDX_RXQ_CMD, 16'h0020 << k, "cause cleared");
      rd_chk(qcc_pkg::IDX_IRQ_STATUS, 16'h0000, "rx cleared");
      wr_reg(qcc_pkg::IDX_RXQ_CMD, 16'h0000);
    end
    $display("test thresholds done");
    complete_run();
  end
endmodule
